// *** design/nvac_pkg.sv ***
// Summary of operation
// - Sixty-four byte array, one byte per access.
// - Location register six bits, upper bits zero.
// - Byte register full eight bits, reset zero.
// - Control holds four bits; upper four read zero.
// - Program permit clear blocks every array write.
// - Write start launches write, clears when done.
// - Write start ignored unless program permit set.
// - Fetch permit clear blocks every array read.
// - Read start launches read, clears when valid.
// - Read start ignored unless fetch permit set.
// - Byte register holds fetched value until next operation.
// - Write timed by free timer, variable length.
// - Write end clears start and raises request.
// - Location, byte direct; control at sector one 40H.
// - Done request stays set until software clears it.
`default_nettype none
package nvac_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TIMER_TICK_NS = 1000;
  localparam int TICK_CYCLES   = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TIME_US = 2000;
  localparam int WRITE_TICKS   = (WRITE_TIME_US * 1000) / TIMER_TICK_NS;
  localparam int READ_CYCLES   = 2;
  localparam int CNT_W         = 16;

  localparam int LOC_W  = 6;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 64;

  localparam logic [7:0] SECTOR_0 = 8'h00;
  localparam logic [7:0] SECTOR_1 = 8'h01;
  localparam logic [7:0] CTRL_OFF = 8'h40;
  localparam logic [7:0] LOC_OFF  = 8'h2E;
  localparam logic [7:0] BYTE_OFF = 8'h2F;

  localparam int RD_START_BIT   = 0;
  localparam int RD_PERMIT_BIT  = 1;
  localparam int WR_START_BIT   = 2;
  localparam int WR_PERMIT_BIT  = 3;

  localparam logic [7:0] LOC_UNUSED_MASK  = 8'hC0;
  localparam logic [7:0] CTRL_UNUSED_MASK = 8'hF0;
  localparam logic [5:0] LOC_RST          = 6'h00;
  localparam logic [7:0] BYTE_RST         = 8'h00;
  localparam logic [7:0] RDATA_RST        = 8'h00;

  typedef enum logic [2:0] {
    NVAC_IDLE  = 3'h1,
    NVAC_READ  = 3'h2,
    NVAC_WRITE = 3'h4
  } nvac_state_type;

endpackage
`default_nettype wire

// *** design/nvac_array.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvac_array #(
  parameter int WRITE_TICKS = nvac_pkg::WRITE_TICKS
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [nvac_pkg::LOC_W-1:0] rd_loc,
  output logic      [7:0]                 rd_data,
  input  wire logic                       wr_start,
  input  wire logic [nvac_pkg::LOC_W-1:0] wr_loc,
  input  wire logic [7:0]                 wr_data,
  input  wire logic                       wr_permit,
  output logic                            wr_done,
  output logic                            wr_commit
);
  localparam int CW = nvac_pkg::CNT_W;

  // The array keeps its contents through reset, as storage that is non-volatile must.
  logic [7:0]                 mem [0:nvac_pkg::DEPTH-1];
  logic [CW-1:0]              pre_r, pre_nxt;
  logic [CW-1:0]              left_r, left_nxt;
  logic                       busy_r, busy_nxt;
  logic [nvac_pkg::LOC_W-1:0] lat_loc_r, lat_loc_nxt;
  logic [7:0]                 lat_data_r, lat_data_nxt;
  logic                       done_nxt, commit_nxt;
  logic                       tick;
  logic                       finish;

  // The prescaler runs freely and is never aligned to a start, so a write lasts a
  // varying number of clock cycles.
  assign tick   = (pre_r == CW'(nvac_pkg::TICK_CYCLES - 1));
  assign finish = busy_r && tick && (left_r == CW'(1));

  always_comb begin
    pre_nxt      = tick ? '0 : pre_r + CW'(1);
    busy_nxt     = busy_r;
    left_nxt     = left_r;
    lat_loc_nxt  = lat_loc_r;
    lat_data_nxt = lat_data_r;
    done_nxt     = finish;
    commit_nxt   = finish && wr_permit;
    if (wr_start && !busy_r) begin
      busy_nxt     = 1'b1;
      left_nxt     = CW'(WRITE_TICKS);
      lat_loc_nxt  = wr_loc;
      lat_data_nxt = wr_data;
    end else if (busy_r && tick) begin
      left_nxt = left_r - CW'(1);
      if (finish) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pre_r      <= '0;
      left_r     <= '0;
      busy_r     <= 1'b0;
      lat_loc_r  <= nvac_pkg::LOC_RST;
      lat_data_r <= nvac_pkg::BYTE_RST;
      wr_done    <= 1'b0;
      wr_commit  <= 1'b0;
    end else begin
      pre_r      <= pre_nxt;
      left_r     <= left_nxt;
      busy_r     <= busy_nxt;
      lat_loc_r  <= lat_loc_nxt;
      lat_data_r <= lat_data_nxt;
      wr_done    <= done_nxt;
      wr_commit  <= commit_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (finish && wr_permit) begin
      mem[lat_loc_r] <= lat_data_r;
    end
    rd_data <= mem[rd_loc];
  end

endmodule
`default_nettype wire

// *** design/nvac_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvac_ctrl #(
  parameter int WRITE_TICKS = nvac_pkg::WRITE_TICKS
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] cpu_sector,
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       nv_done_clear,
  output logic            nv_done_request,
  output logic            nv_write_done,
  output logic            nv_busy
);
  localparam int RCW      = 2;
  localparam int AGE_W    = 20;
  localparam int WR_AGE_MAX = (WRITE_TICKS + 2) * nvac_pkg::TICK_CYCLES + 4;

  nvac_pkg::nvac_state_type state_r, state_nxt;

  logic [nvac_pkg::LOC_W-1:0] loc_r, loc_nxt;
  logic [7:0]                 byte_r, byte_nxt;
  logic                       program_permit_r, program_permit_nxt;
  logic                       wr_start_r, wr_start_nxt;
  logic                       fetch_permit_r, fetch_permit_nxt;
  logic                       rd_start_r, rd_start_nxt;
  logic [RCW-1:0]             rcnt_r, rcnt_nxt;
  logic                       done_req_r, done_req_nxt;
  logic [7:0]                 rdata_r, rdata_nxt;
  logic [AGE_W-1:0]           wr_age_r, wr_age_nxt;
  logic                       hit_loc, hit_byte, hit_ctrl;
  logic                       wr_ctrl;
  logic                       arr_start;
  logic [7:0]                 arr_rd_data;
  logic                       arr_done;
  logic                       arr_commit;
  logic [7:0]                 ctrl_view;

  function automatic logic reg_hit(input logic [7:0] sec,
                                   input logic [7:0] adr,
                                   input logic [7:0] off,
                                   input logic       ctrl_only);
    logic sec_ok;
    sec_ok = (sec == nvac_pkg::SECTOR_1) || (!ctrl_only && sec == nvac_pkg::SECTOR_0);
    return sec_ok && (adr == off);
  endfunction

  // Location and byte answer in both sectors; control only behind the sector-one pointer.
  assign hit_loc  = reg_hit(cpu_sector, cpu_addr, nvac_pkg::LOC_OFF, 1'b0);
  assign hit_byte = reg_hit(cpu_sector, cpu_addr, nvac_pkg::BYTE_OFF, 1'b0);
  assign hit_ctrl = reg_hit(cpu_sector, cpu_addr, nvac_pkg::CTRL_OFF, 1'b1);
  assign wr_ctrl  = cpu_wr && hit_ctrl;

  always_comb begin
    ctrl_view                          = 8'h00;
    ctrl_view[nvac_pkg::RD_START_BIT]  = rd_start_r;
    ctrl_view[nvac_pkg::RD_PERMIT_BIT] = fetch_permit_r;
    ctrl_view[nvac_pkg::WR_START_BIT]  = wr_start_r;
    ctrl_view[nvac_pkg::WR_PERMIT_BIT] = program_permit_r;
  end

  always_comb begin
    state_nxt          = state_r;
    loc_nxt            = loc_r;
    byte_nxt           = byte_r;
    program_permit_nxt = program_permit_r;
    fetch_permit_nxt   = fetch_permit_r;
    wr_start_nxt       = wr_start_r;
    rd_start_nxt       = rd_start_r;
    rcnt_nxt           = rcnt_r;
    arr_start          = 1'b0;
    if (cpu_wr && hit_loc) begin
      loc_nxt = cpu_wdata[nvac_pkg::LOC_W-1:0];
    end
    if (cpu_wr && hit_byte) begin
      byte_nxt = cpu_wdata;
    end
    if (wr_ctrl) begin
      program_permit_nxt = cpu_wdata[nvac_pkg::WR_PERMIT_BIT];
      fetch_permit_nxt   = cpu_wdata[nvac_pkg::RD_PERMIT_BIT];
    end
    case (state_r)
      nvac_pkg::NVAC_IDLE: begin
        // Starts look at the permits held before this access, so setting permit and
        // start in one store launches nothing. A store with both starts runs the write if program permit is held.
        if (wr_ctrl && cpu_wdata[nvac_pkg::WR_START_BIT] && program_permit_r) begin
          wr_start_nxt = 1'b1;
          arr_start    = 1'b1;
          state_nxt    = nvac_pkg::NVAC_WRITE;
        end else if (wr_ctrl && cpu_wdata[nvac_pkg::RD_START_BIT] && fetch_permit_r) begin
          rd_start_nxt = 1'b1;
          rcnt_nxt     = '0;
          state_nxt    = nvac_pkg::NVAC_READ;
        end
      end
      nvac_pkg::NVAC_READ: begin
        // Start bits written now are dropped; only the permits move.
        if (rcnt_r == RCW'(nvac_pkg::READ_CYCLES - 1)) begin
          if (fetch_permit_r) begin
            byte_nxt = arr_rd_data;
          end
          rd_start_nxt = 1'b0;
          state_nxt    = nvac_pkg::NVAC_IDLE;
        end else begin
          rcnt_nxt = rcnt_r + RCW'(1);
        end
      end
      nvac_pkg::NVAC_WRITE: begin
        if (arr_done) begin
          wr_start_nxt = 1'b0;
          state_nxt    = nvac_pkg::NVAC_IDLE;
        end
      end
      default: begin
        state_nxt    = nvac_pkg::NVAC_IDLE;
        wr_start_nxt = 1'b0;
        rd_start_nxt = 1'b0;
      end
    endcase
  end

  always_comb begin
    // A completion in the clearing cycle survives, so no request is lost.
    done_req_nxt = done_req_r;
    if (arr_done) begin
      done_req_nxt = 1'b1;
    end else if (nv_done_clear) begin
      done_req_nxt = 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (cpu_rd) begin
      if (hit_loc) begin
        rdata_nxt = 8'(loc_r);
      end else if (hit_byte) begin
        rdata_nxt = byte_r;
      end else if (hit_ctrl) begin
        rdata_nxt = ctrl_view;
      end else begin
        rdata_nxt = nvac_pkg::RDATA_RST;
      end
    end
  end

  always_comb begin
    wr_age_nxt = '0;
    if (state_r == nvac_pkg::NVAC_WRITE) begin
      wr_age_nxt = wr_age_r + AGE_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r          <= nvac_pkg::NVAC_IDLE;
      loc_r            <= nvac_pkg::LOC_RST;
      byte_r           <= nvac_pkg::BYTE_RST;
      program_permit_r <= 1'b0;
      wr_start_r       <= 1'b0;
      fetch_permit_r   <= 1'b0;
      rd_start_r       <= 1'b0;
      rcnt_r           <= '0;
      done_req_r       <= 1'b0;
      rdata_r          <= nvac_pkg::RDATA_RST;
      wr_age_r         <= '0;
    end else begin
      state_r          <= state_nxt;
      loc_r            <= loc_nxt;
      byte_r           <= byte_nxt;
      program_permit_r <= program_permit_nxt;
      wr_start_r       <= wr_start_nxt;
      fetch_permit_r   <= fetch_permit_nxt;
      rd_start_r       <= rd_start_nxt;
      rcnt_r           <= rcnt_nxt;
      done_req_r       <= done_req_nxt;
      rdata_r          <= rdata_nxt;
      wr_age_r         <= wr_age_nxt;
    end
  end

  // The permit is passed live so that clearing it mid-cycle still blocks the commit.
  nvac_array #(
    .WRITE_TICKS (WRITE_TICKS)
  ) u_array (
    .clock     (clock),
    .rst       (rst),
    .rd_loc    (loc_r),
    .rd_data   (arr_rd_data),
    .wr_start  (arr_start),
    .wr_loc    (loc_r),
    .wr_data   (byte_r),
    .wr_permit (program_permit_r),
    .wr_done   (arr_done),
    .wr_commit (arr_commit)
  );

  assign cpu_rdata       = rdata_r;
  assign nv_done_request = done_req_r;
  assign nv_write_done   = arr_done;
  assign nv_busy         = wr_start_r || rd_start_r;

  // Reset masks every check, so the cleared state is never judged against a stale past.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_loc_upper_zero: assert property (
    cpu_rd && hit_loc |=> (cpu_rdata & nvac_pkg::LOC_UNUSED_MASK) == 8'h00)
    else $error("location read shows upper bits set");

  chk_ctrl_upper_zero: assert property (
    cpu_rd && hit_ctrl |=> (cpu_rdata & nvac_pkg::CTRL_UNUSED_MASK) == 8'h00)
    else $error("control read shows upper bits set");

  chk_commit_needs_permit: assert property (
    arr_commit |-> $past(program_permit_r))
    else $error("array written without program permit");

  chk_write_refused: assert property (
    state_r == nvac_pkg::NVAC_IDLE && wr_ctrl && cpu_wdata[nvac_pkg::WR_START_BIT]
      && !program_permit_r && !cpu_wdata[nvac_pkg::RD_START_BIT]
      |=> state_r == nvac_pkg::NVAC_IDLE && !wr_start_r)
    else $error("write launched without permit");

  chk_read_refused: assert property (
    state_r == nvac_pkg::NVAC_IDLE && wr_ctrl && cpu_wdata[nvac_pkg::RD_START_BIT]
      && !fetch_permit_r && !cpu_wdata[nvac_pkg::WR_START_BIT]
      |=> !rd_start_r)
    else $error("read launched without permit");

  chk_read_length: assert property (
    $rose(rd_start_r) |-> rd_start_r [*2] ##1 !rd_start_r)
    else $error("read start bit did not clear after two cycles");

  chk_byte_hold: assert property (
    state_r == nvac_pkg::NVAC_IDLE && !(cpu_wr && hit_byte) |=> $stable(byte_r))
    else $error("byte register changed without an operation");

  chk_done_flags: assert property (
    arr_done |=> done_req_r && !wr_start_r && state_r == nvac_pkg::NVAC_IDLE)
    else $error("write end did not clear start and raise request");

  chk_done_sticky: assert property (
    done_req_r && !nv_done_clear |=> done_req_r)
    else $error("done request dropped without a clear");

  chk_busy_ignore: assert property (
    state_r == nvac_pkg::NVAC_WRITE && wr_ctrl |=> !rd_start_r)
    else $error("read started during a write");

  chk_write_bounded: assert property (
    wr_age_r <= AGE_W'(WR_AGE_MAX))
    else $error("write cycle ran past its timer bound");

  chk_write_launch: assert property (
    state_r == nvac_pkg::NVAC_IDLE && wr_ctrl && cpu_wdata[nvac_pkg::WR_START_BIT]
      && program_permit_r |=> wr_start_r && state_r == nvac_pkg::NVAC_WRITE)
    else $error("permitted write start did not launch a cycle");

  chk_read_launch: assert property (
    state_r == nvac_pkg::NVAC_IDLE && wr_ctrl && cpu_wdata[nvac_pkg::RD_START_BIT]
      && fetch_permit_r && !cpu_wdata[nvac_pkg::WR_START_BIT] |=> rd_start_r)
    else $error("permitted read start did not launch a cycle");

  // Only a read whose permit still stands may refresh the byte register.
  chk_read_loads: assert property (
    state_r == nvac_pkg::NVAC_READ && rcnt_r == RCW'(nvac_pkg::READ_CYCLES - 1)
      && fetch_permit_r |=> byte_r == $past(arr_rd_data))
    else $error("finished read did not load the fetched byte");

  chk_read_busy_ignore: assert property (
    state_r == nvac_pkg::NVAC_READ && wr_ctrl |=> !wr_start_r)
    else $error("write started during a read");

  chk_start_gated: assert property (
    arr_start |-> state_r == nvac_pkg::NVAC_IDLE && program_permit_r)
    else $error("array cycle launched while busy or without permit");

  chk_done_pulse: assert property (
    arr_done |=> !arr_done)
    else $error("write done held longer than one cycle");

  chk_ctrl_sector: assert property (
    cpu_rd && cpu_sector == nvac_pkg::SECTOR_0 && cpu_addr == nvac_pkg::CTRL_OFF
      |=> cpu_rdata == nvac_pkg::RDATA_RST)
    else $error("control answered outside sector one");

  chk_byte_store: assert property (
    cpu_wr && hit_byte && state_r == nvac_pkg::NVAC_IDLE |=> byte_r == $past(cpu_wdata))
    else $error("byte store did not land");

  chk_loc_store: assert property (
    cpu_wr && hit_loc |=> 8'(loc_r) == ($past(cpu_wdata) & ~nvac_pkg::LOC_UNUSED_MASK))
    else $error("location store did not land");

  cov_read_done:  cover property ($fell(rd_start_r));
  cov_read_busy:  cover property (state_r == nvac_pkg::NVAC_READ && wr_ctrl);
  cov_write_done: cover property ($fell(wr_start_r));
  cov_set_clear:  cover property (arr_done && nv_done_clear);
  cov_refused:    cover property (wr_ctrl && cpu_wdata[nvac_pkg::WR_START_BIT] && !program_permit_r);

endmodule
`default_nettype wire

// *** dv/nvac_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvac_cpu_model (
  input  wire logic       clock,
  output logic      [7:0] cpu_sector,
  output logic      [7:0] cpu_addr,
  output logic            cpu_wr,
  output logic            cpu_rd,
  output logic      [7:0] cpu_wdata,
  input  wire logic [7:0] cpu_rdata
);
  initial begin
    cpu_sector = 8'h00;
    cpu_addr   = 8'h00;
    cpu_wr     = 1'b0;
    cpu_rd     = 1'b0;
    cpu_wdata  = 8'h00;
  end

  // Place 0 location, 1 byte, 2 control, 3 control offset in sector 0 (unmapped),
  // 4 byte reached through sector one.
  function automatic logic [15:0] place(input int sel);
    case (sel)
      0: return {nvac_pkg::SECTOR_0, nvac_pkg::LOC_OFF};
      1: return {nvac_pkg::SECTOR_0, nvac_pkg::BYTE_OFF};
      2: return {nvac_pkg::SECTOR_1, nvac_pkg::CTRL_OFF};
      4: return {nvac_pkg::SECTOR_1, nvac_pkg::BYTE_OFF};
      default: return {nvac_pkg::SECTOR_0, nvac_pkg::CTRL_OFF};
    endcase
  endfunction

  // Released strobes drop low and address and data are inverted, so a stale value can never pass as a held one.
  task automatic drop_bus();
    cpu_wr     <= 1'b0;
    cpu_rd     <= 1'b0;
    cpu_sector <= ~cpu_sector;
    cpu_addr   <= ~cpu_addr;
    cpu_wdata  <= ~cpu_wdata;
  endtask

  task automatic store(input int sel, input logic [7:0] data);
    @(posedge clock);
    {cpu_sector, cpu_addr} <= place(sel);
    cpu_wdata <= data;
    cpu_wr    <= 1'b1;
    @(posedge clock);
    drop_bus();
  endtask

  task automatic load(input int sel, output logic [7:0] data);
    @(posedge clock);
    {cpu_sector, cpu_addr} <= place(sel);
    cpu_rd <= 1'b1;
    @(posedge clock);
    drop_bus();
    @(posedge clock);
    #1;
    data = cpu_rdata;
  endtask

  task automatic poll(input int bitpos, output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 100; i++) begin
      load(2, v);
      if (v[bitpos] === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
  endtask

  task automatic nv_write(input logic [5:0] loc, input logic [7:0] data,
                          input logic [7:0] m1, input logic [7:0] m2,
                          output logic ok, output logic [7:0] snap);
    store(0, {2'h0, loc});
    store(1, data);
    // Permit and start go out back to back, so nothing can slip in between them.
    store(2, 8'h08);
    store(2, 8'h0C);
    store(2, m1);
    store(2, m2);
    load(2, snap);
    poll(nvac_pkg::WR_START_BIT, ok);
    store(2, 8'h00);
  endtask

  task automatic nv_read(input logic [5:0] loc, output logic ok, output logic [7:0] data);
    store(2, 8'h02);
    store(0, {2'h0, loc});
    store(2, 8'h03);
    poll(nvac_pkg::RD_START_BIT, ok);
    store(2, 8'h00);
    load(1, data);
  endtask
endmodule
`default_nettype wire

// *** dv/nvac_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvac_ctrl_bench;
  localparam int WT = 3;
  // The start bit spans a partial first tick, WT - 1 whole ticks and the done cycle.
  localparam int BUSY_MIN = (WT - 1) * nvac_pkg::TICK_CYCLES + 2;
  localparam int BUSY_MAX = WT * nvac_pkg::TICK_CYCLES + 1;
  logic       clock;
  logic       rst;
  logic       nv_done_clear;
  logic [7:0] cpu_sector;
  logic [7:0] cpu_addr;
  logic       cpu_wr;
  logic       cpu_rd;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic       nv_done_request;
  logic       nv_write_done;
  logic       nv_busy;
  logic       ok;
  logic [7:0] d;
  logic [7:0] snap;
  int         n_fail;
  int         compares;
  int         busy_cnt;
  int         done_cnt;

  nvac_ctrl #(.WRITE_TICKS(WT)) dut (
    .clock(clock), .rst(rst), .cpu_sector(cpu_sector), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .nv_done_clear(nv_done_clear), .nv_done_request(nv_done_request),
    .nv_write_done(nv_write_done), .nv_busy(nv_busy)
  );

  nvac_cpu_model cpu (
    .clock(clock), .cpu_sector(cpu_sector), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    if (nv_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (nv_write_done === 1'b1) done_cnt <= done_cnt + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A poll that ran out of its bound leaves nothing useful to test after it.
  task automatic need_ok(input logic flag);
    chk({7'h00, flag}, 8'h01);
    if (flag !== 1'b1) stop_test();
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    nv_done_clear = 1'b0;
    n_fail = 0;
    compares = 0;
    busy_cnt = 0;
    done_cnt = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cpu.load(0, d);
    chk(d, 8'h00);
    cpu.load(1, d);
    chk(d, 8'h00);
    cpu.load(2, d);
    chk(d, 8'h00);
    $display("test reset_values done");

    cpu.store(0, 8'hFF);
    cpu.load(0, d);
    chk(d, 8'h3F);
    cpu.store(1, 8'hA5);
    cpu.load(1, d);
    chk(d, 8'hA5);
    cpu.store(4, 8'h3C);
    cpu.load(1, d);
    chk(d, 8'h3C);
    cpu.store(2, 8'hF2);
    cpu.load(2, d);
    chk(d, 8'h02);
    cpu.store(3, 8'h0A);
    cpu.load(2, d);
    chk(d, 8'h02);
    cpu.load(3, d);
    chk(d, 8'h00);
    cpu.store(2, 8'h00);
    cpu.store(2, 8'h04);
    cpu.load(2, d);
    chk(d, 8'h00);
    cpu.store(2, 8'h01);
    cpu.load(2, d);
    chk(d, 8'h00);
    chk({7'h00, nv_busy}, 8'h00);
    $display("test fields_and_permits done");

    busy_cnt = 0;
    cpu.nv_write(6'h05, 8'h5A, 8'h0A, 8'h0B, ok, snap);
    need_ok(ok);
    chk(snap, 8'h0E);
    chk({7'h00, busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX}, 8'h01);
    chk(done_cnt[7:0], 8'h01);
    chk({7'h00, nv_done_request}, 8'h01);
    @(posedge clock);
    nv_done_clear <= 1'b1;
    @(posedge clock);
    nv_done_clear <= 1'b0;
    @(posedge clock);
    #1;
    chk({7'h00, nv_done_request}, 8'h00);
    $display("test write_cycle done");

    cpu.store(1, 8'h00);
    cpu.nv_read(6'h05, ok, d);
    need_ok(ok);
    chk(d, 8'h5A);
    cpu.store(0, 8'h09);
    cpu.load(1, d);
    chk(d, 8'h5A);
    cpu.store(0, 8'h05);
    cpu.store(2, 8'h0A);
    cpu.store(2, 8'h0B);
    cpu.store(2, 8'h0C);
    cpu.load(2, d);
    chk(d, 8'h08);
    cpu.store(2, 8'h00);
    $display("test read_cycle done");

    cpu.nv_write(6'h05, 8'h77, 8'h04, 8'h04, ok, snap);
    need_ok(ok);
    chk(snap, 8'h04);
    chk(done_cnt[7:0], 8'h02);
    chk({7'h00, nv_done_request}, 8'h01);
    cpu.nv_read(6'h05, ok, d);
    need_ok(ok);
    chk(d, 8'h5A);
    cpu.nv_write(6'h3F, 8'hC3, 8'h08, 8'h08, ok, snap);
    need_ok(ok);
    cpu.nv_read(6'h3F, ok, d);
    chk(d, 8'hC3);
    cpu.nv_read(6'h05, ok, d);
    chk(d, 8'h5A);
    $display("test permit_drop_and_edges done");
    stop_test();
  end
endmodule
`default_nettype wire
